// *** rtl/pwt_top.sv ***
/*
  pci window translation: target window 1 remap, target control (latency rule,
  prefetch) and three masked initiator windows with command selection.
  assumes a module-base relative register port, pci signals already
  synchronous to clk except the frame pin, and one 50 MHz clock.
*/
//
// Contract
// - bar1 hit replaces top two address bits
// - window disabled: bar1 hit aborts transaction
// - translation value rewritable at run time
// - latency rule disable suppresses 16/8 disconnects
// - only internal reads retried; writes held
// - no timeout; inbound denied while blocked
// - prefetch continues while frame and space
// - prefetch only bar1; read multiple always
// - translate unmasked bits, pass masked bits
// - translation always active; identity by equals
// - three independent identically laid out windows
// - control bit 3 selects memory or io
// - bits 2:1 pick memory read command
// - control bit 0 gates window decoding
// - config mapping turns io windows config
`timescale 1ns/1ps
`default_nettype none
module pwt_top (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // register port
    input  wire logic                 reg_sel,
    input  wire logic                 reg_wr,
    input  wire logic [11:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic      [31:0]          reg_rdata,
    output logic                      reg_ack,
    // initiator side request and answer
    input  wire pwt_pkg::pwt_ini_req_t ini_req,
    output pwt_pkg::pwt_ini_ans_t     ini_ans,
    // target side request and answer
    input  wire pwt_pkg::pwt_tgt_req_t tgt_req,
    output pwt_pkg::pwt_tgt_ans_t     tgt_ans,
    // target flow status
    input  wire logic                 pci_frame_pin_n,
    input  wire logic                 tgt_data_beat,
    input  wire logic                 tgt_first_beat,
    input  wire logic                 rd_buf_space,
    input  wire logic                 wr_buf_full,
    input  wire logic                 int_write_open,
    input  wire logic                 rd_prefetched,
    input  wire logic                 int_write_posted,
    input  wire logic                 io_write_done,
    input  wire logic                 int_read_blocked,
    output logic                      tgt_retry,
    output logic                      tgt_deny_inbound,
    output logic                      tgt_fetch_line,
    output logic                      int_read_retry,
    output logic                      int_write_hold
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [31:0] xlt1_q, xlt1_d;
    logic [31:0] tctl_q, tctl_d;
    logic [31:0] wcfg_q, wcfg_d;
    logic [31:0] cadr_q, cadr_d;
    logic [31:0] rdat_q, rdat_d;
    logic        ack_q, ack_d;
    logic        win_wr;
    logic [1:0]  win_idx;
    logic [31:0] win_rd;
    logic [31:0] win_word [pwt_pkg::NUM_WIN];
    logic        rd_win_q, rd_win_d;

    // map a register offset to a window slot, 3 when none
    function automatic logic [1:0] win_slot(input logic [11:0] a);
        unique case (a)
            pwt_pkg::OFS_INI_WIN0_MAP: win_slot = 2'h0;
            pwt_pkg::OFS_INI_WIN1_MAP: win_slot = 2'h1;
            pwt_pkg::OFS_INI_WIN2_MAP: win_slot = 2'h2;
            default:                   win_slot = 2'h3;
        endcase
    endfunction

    assign win_idx = win_slot(reg_addr);
    assign win_wr  = reg_sel && reg_wr && (win_idx != 2'h3);

    always_comb begin
        xlt1_d   = xlt1_q;
        tctl_d   = tctl_q;
        wcfg_d   = wcfg_q;
        cadr_d   = cadr_q;
        rdat_d   = pwt_pkg::RST_ZERO;
        rd_win_d = 1'b0;
        ack_d    = reg_sel;
        if (reg_sel && reg_wr) begin
            unique case (reg_addr)
                pwt_pkg::OFS_TGT_WIN1_XLT: xlt1_d = reg_wdata & pwt_pkg::MSK_TGT_WIN1_XLT;
                pwt_pkg::OFS_TGT_CONTROL:  tctl_d = reg_wdata & pwt_pkg::MSK_TGT_CONTROL;
                pwt_pkg::OFS_INI_WIN_CFG:  wcfg_d = reg_wdata & pwt_pkg::MSK_INI_WIN_CFG;
                pwt_pkg::OFS_CFG_ADDR:     cadr_d = reg_wdata & pwt_pkg::MSK_CFG_ADDR;
                default: ;
            endcase
        end else if (reg_sel) begin
            unique case (reg_addr)
                pwt_pkg::OFS_TGT_WIN1_XLT: rdat_d = xlt1_q;
                pwt_pkg::OFS_TGT_CONTROL:  rdat_d = tctl_q;
                pwt_pkg::OFS_INI_WIN_CFG:  rdat_d = wcfg_q;
                pwt_pkg::OFS_CFG_ADDR:     rdat_d = cadr_q;
                default:                   rd_win_d = (win_idx != 2'h3);
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            xlt1_q   <= pwt_pkg::RST_ZERO;
            tctl_q   <= pwt_pkg::RST_ZERO;
            wcfg_q   <= pwt_pkg::RST_ZERO;
            cadr_q   <= pwt_pkg::RST_ZERO;
            rdat_q   <= pwt_pkg::RST_ZERO;
            ack_q    <= 1'b0;
            rd_win_q <= 1'b0;
        end else begin
            xlt1_q   <= xlt1_d;
            tctl_q   <= tctl_d;
            wcfg_q   <= wcfg_d;
            cadr_q   <= cadr_d;
            rdat_q   <= rdat_d;
            ack_q    <= ack_d;
            rd_win_q <= rd_win_d;
        end
    end

    pwt_win_regs u_win (
        .clk     (clk),
        .reset_n (reset_n),
        .wr_en   (win_wr),
        .wr_idx  (win_idx),
        .wr_data (reg_wdata),
        .rd_idx  (win_idx),
        .rd_data (win_rd),
        .words   (win_word)
    );

    assign reg_rdata = rd_win_q ? win_rd : rdat_q;
    assign reg_ack   = ack_q;

    ////////////////////////////////////////////////////////////////////////////
    // initiator window decode

    logic [3:0] win_ctl [pwt_pkg::NUM_WIN];
    logic [2:0] win_hit;
    logic [7:0] win_top [pwt_pkg::NUM_WIN];

    assign win_ctl[0] = wcfg_q[pwt_pkg::POS_WIN0_CTL +: 4];
    assign win_ctl[1] = wcfg_q[pwt_pkg::POS_WIN1_CTL +: 4];
    assign win_ctl[2] = wcfg_q[pwt_pkg::POS_WIN2_CTL +: 4];

    for (genvar g = 0; g < pwt_pkg::NUM_WIN; g++) begin : g_win
        logic [7:0] base;
        logic [7:0] mask;
        logic [7:0] xlt;
        assign base = win_word[g][pwt_pkg::POS_WIN_BASE +: 8];
        assign mask = win_word[g][pwt_pkg::POS_WIN_MASK +: 8];
        assign xlt  = win_word[g][pwt_pkg::POS_WIN_XLT +: 8];
        assign win_hit[g] = win_ctl[g][pwt_pkg::POS_CTL_EN]
            && (((ini_req.addr[31:24] ^ base) & ~mask) == 8'h00);
        assign win_top[g] = (xlt & ~mask) | (ini_req.addr[31:24] & mask);
    end

    pwt_pkg::pwt_ini_ans_t ini_q, ini_d;
    logic [1:0]            sel;
    logic [3:0]            ctl;

    always_comb begin
        sel = 2'h0;
        if (win_hit[0]) begin
            sel = 2'h0;
        end else if (win_hit[1]) begin
            sel = 2'h1;
        end else begin
            sel = 2'h2;
        end
        ctl = win_ctl[sel];
        ini_d           = '0;
        ini_d.hit       = ini_req.valid && (win_hit != 3'h0);
        ini_d.win       = sel;
        ini_d.addr      = {win_top[sel], ini_req.addr[23:0]};
        if (ctl[pwt_pkg::POS_CTL_IO]) begin
            ini_d.cfg_cycle = cadr_q[pwt_pkg::POS_CFG_MAP_EN];
            if (cadr_q[pwt_pkg::POS_CFG_MAP_EN]) begin
                ini_d.cmd = ini_req.write ? pwt_pkg::CMD_CFG_WR : pwt_pkg::CMD_CFG_RD;
            end else begin
                ini_d.cmd = ini_req.write ? pwt_pkg::CMD_IO_WR : pwt_pkg::CMD_IO_RD;
            end
        end else if (ini_req.write) begin
            ini_d.cmd = pwt_pkg::CMD_MEM_WR;
        end else begin
            unique case (ctl[pwt_pkg::POS_CTL_RCMD +: 2])
                pwt_pkg::RCS_READ:     ini_d.cmd = pwt_pkg::CMD_MEM_RD;
                pwt_pkg::RCS_LINE:     ini_d.cmd = pwt_pkg::CMD_MEM_RD_L;
                pwt_pkg::RCS_MULTIPLE: ini_d.cmd = pwt_pkg::CMD_MEM_RD_M;
                default:               ini_d.cmd = pwt_pkg::CMD_MEM_RD;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ini_q <= '0;
        end else begin
            ini_q <= ini_d;
        end
    end

    assign ini_ans = ini_q;

    ////////////////////////////////////////////////////////////////////////////
    // target window 1 and flow control

    logic frame_s1_q, frame_s2_q;
    logic frame_act;
    logic lat_dis;
    logic pref_en;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_s1_q <= 1'b1;
            frame_s2_q <= 1'b1;
        end else begin
            frame_s1_q <= pci_frame_pin_n;
            frame_s2_q <= frame_s1_q;
        end
    end

    assign frame_act = !frame_s2_q;
    assign lat_dis   = tctl_q[pwt_pkg::POS_LAT_DIS];
    assign pref_en   = tctl_q[pwt_pkg::POS_PREFETCH];

    pwt_pkg::pwt_tgt_ans_t tgt_q, tgt_d;
    logic [4:0] lat_q, lat_d;
    logic       first_q, first_d;
    logic       pf_q, pf_d;
    logic       retry_q, retry_d;
    logic       deny_q, deny_d;
    logic       fetch_q, fetch_d;
    logic       rrty_q, rrty_d;
    logic       hold_q, hold_d;
    logic       blocked;

    always_comb begin
        tgt_d          = '0;
        tgt_d.hit      = tgt_req.valid;
        tgt_d.abort    = tgt_req.valid && !xlt1_q[pwt_pkg::POS_XLT_EN];
        tgt_d.addr     = {xlt1_q[pwt_pkg::POS_XLT_HI +: 2], tgt_req.addr[29:0]};
        tgt_d.prefetch = tgt_req.valid && tgt_req.read
                         && (pref_en || tgt_req.mem_rd_mult);
        pf_d = pf_q;
        if (tgt_d.prefetch && !tgt_d.abort) begin
            pf_d = 1'b1;
        end else if (!frame_act) begin
            pf_d = 1'b0;
        end
        fetch_d = pf_q && frame_act && rd_buf_space;
        // latency counter, restarts on each data beat
        first_d = first_q;
        lat_d   = lat_q;
        retry_d = 1'b0;
        if (!frame_act) begin
            first_d = 1'b1;
            lat_d   = 5'h00;
        end else if (tgt_data_beat) begin
            first_d = tgt_first_beat ? 1'b1 : 1'b0;
            lat_d   = 5'h00;
        end else begin
            lat_d = lat_q + 5'h01;
            if (!lat_dis && (lat_d >= (first_q ? pwt_pkg::LAT_FIRST : pwt_pkg::LAT_NEXT))) begin
                retry_d = 1'b1;
                lat_d   = 5'h00;
            end
            if (lat_dis && lat_q == 5'h1F) begin
                lat_d = lat_q;
            end
        end
        blocked = int_write_open && (!rd_prefetched || wr_buf_full);
        deny_d  = lat_dis && blocked;
        rrty_d  = int_read_blocked;
        hold_d  = int_write_open && !(int_write_posted || io_write_done);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tgt_q   <= '0;
            lat_q   <= 5'h00;
            first_q <= 1'b1;
            pf_q    <= 1'b0;
            retry_q <= 1'b0;
            deny_q  <= 1'b0;
            fetch_q <= 1'b0;
            rrty_q  <= 1'b0;
            hold_q  <= 1'b0;
        end else begin
            tgt_q   <= tgt_d;
            lat_q   <= lat_d;
            first_q <= first_d;
            pf_q    <= pf_d;
            retry_q <= retry_d;
            deny_q  <= deny_d;
            fetch_q <= fetch_d;
            rrty_q  <= rrty_d;
            hold_q  <= hold_d;
        end
    end

    assign tgt_ans          = tgt_q;
    assign tgt_retry        = retry_q;
    assign tgt_deny_inbound = deny_q;
    assign tgt_fetch_line   = fetch_q;
    assign int_read_retry   = rrty_q;
    assign int_write_hold   = hold_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_bar1_abort_off: assert property (@(posedge clk) disable iff (!reset_n)
        tgt_req.valid && !xlt1_q[0] |=> tgt_ans.abort)
        else $error("bar1 hit with window off not aborted");

    a_bar1_top_bits: assert property (@(posedge clk) disable iff (!reset_n)
        tgt_req.valid |=> tgt_ans.addr[31:30] == $past(xlt1_q[31:30]))
        else $error("bar1 top bits not translated");

    a_no_retry_lat: assert property (@(posedge clk) disable iff (!reset_n)
        lat_dis && $past(lat_dis) |-> !tgt_retry)
        else $error("latency retry while rule disabled");

    a_deny_blocked: assert property (@(posedge clk) disable iff (!reset_n)
        lat_dis && int_write_open && wr_buf_full |=> tgt_deny_inbound)
        else $error("inbound not denied while blocked");

    a_fetch_needs_frame: assert property (@(posedge clk) disable iff (!reset_n)
        tgt_fetch_line |-> $past(frame_act) && $past(rd_buf_space))
        else $error("fetch without frame or space");

    a_win_disabled: assert property (@(posedge clk) disable iff (!reset_n)
        ini_req.valid && win_ctl[0][0] == 1'b0 && win_ctl[1][0] == 1'b0
        && win_ctl[2][0] == 1'b0 |=> !ini_ans.hit)
        else $error("hit on disabled windows");

    a_low_win_wins: assert property (@(posedge clk) disable iff (!reset_n)
        ini_req.valid && win_hit[0] |=> ini_ans.win == 2'h0)
        else $error("lowest window not chosen");

    a_io_no_memrd: assert property (@(posedge clk) disable iff (!reset_n)
        ini_req.valid && win_hit[0] && win_ctl[0][3] && !cadr_q[31] && !ini_req.write
        |=> ini_ans.cmd == pwt_pkg::CMD_IO_RD)
        else $error("io window did not give io read");

endmodule
`default_nettype wire

// *** rtl/pwt_pkg.sv ***
/*
  package of the pci window translation block: register offsets, field positions,
  reset values, command codes and the packed request and answer carriers.
  assumes a module-base relative register port and a single 50 MHz clock.
*/
package pwt_pkg;

    // register offsets relative to module_base
    localparam logic [11:0] OFS_TGT_WIN1_XLT = 12'hB68;
    localparam logic [11:0] OFS_TGT_CONTROL  = 12'hB6C;
    localparam logic [11:0] OFS_INI_WIN0_MAP = 12'hB70;
    localparam logic [11:0] OFS_INI_WIN1_MAP = 12'hB74;
    localparam logic [11:0] OFS_INI_WIN2_MAP = 12'hB78;
    localparam logic [11:0] OFS_INI_WIN_CFG  = 12'hB80;
    localparam logic [11:0] OFS_CFG_ADDR     = 12'hB8C;

    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // writable bit masks
    localparam logic [31:0] MSK_TGT_WIN1_XLT = 32'hC000_0001;
    localparam logic [31:0] MSK_TGT_CONTROL  = 32'h0101_0000;
    localparam logic [31:0] MSK_INI_WIN_MAP  = 32'hFFFF_FF00;
    localparam logic [31:0] MSK_INI_WIN_CFG  = 32'h0F0F_0F00;
    localparam logic [31:0] MSK_CFG_ADDR     = 32'h8000_0000;

    // field positions
    localparam int POS_XLT_HI      = 30;
    localparam int POS_XLT_EN      = 0;
    localparam int POS_LAT_DIS     = 24;
    localparam int POS_PREFETCH    = 16;
    localparam int POS_WIN_BASE    = 24;
    localparam int POS_WIN_MASK    = 16;
    localparam int POS_WIN_XLT     = 8;
    localparam int POS_CFG_MAP_EN  = 31;
    localparam int POS_CTL_IO      = 3;
    localparam int POS_CTL_RCMD    = 1;
    localparam int POS_CTL_EN      = 0;
    localparam int POS_WIN0_CTL    = 24;
    localparam int POS_WIN1_CTL    = 16;
    localparam int POS_WIN2_CTL    = 8;

    // pci latency rule limits, in pci clocks
    localparam logic [4:0] LAT_FIRST = 5'h10;
    localparam logic [4:0] LAT_NEXT  = 5'h08;

    localparam int NUM_WIN = 3;

    // pci bus commands
    localparam logic [3:0] CMD_INT_ACK   = 4'h0;
    localparam logic [3:0] CMD_IO_RD     = 4'h2;
    localparam logic [3:0] CMD_IO_WR     = 4'h3;
    localparam logic [3:0] CMD_MEM_RD    = 4'h6;
    localparam logic [3:0] CMD_MEM_WR    = 4'h7;
    localparam logic [3:0] CMD_CFG_RD    = 4'hA;
    localparam logic [3:0] CMD_CFG_WR    = 4'hB;
    localparam logic [3:0] CMD_MEM_RD_M  = 4'hC;
    localparam logic [3:0] CMD_MEM_RD_L  = 4'hE;

    // read command select codes
    localparam logic [1:0] RCS_READ      = 2'h0;
    localparam logic [1:0] RCS_LINE      = 2'h1;
    localparam logic [1:0] RCS_MULTIPLE  = 2'h2;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } pwt_ini_req_t;

    typedef struct packed {
        logic        hit;
        logic [1:0]  win;
        logic        cfg_cycle;
        logic [3:0]  cmd;
        logic [31:0] addr;
    } pwt_ini_ans_t;

    typedef struct packed {
        logic        valid;
        logic        mem_rd_mult;
        logic        read;
        logic [31:0] addr;
    } pwt_tgt_req_t;

    typedef struct packed {
        logic        hit;
        logic        abort;
        logic        prefetch;
        logic [31:0] addr;
    } pwt_tgt_ans_t;

endpackage

// *** rtl/pwt_win_regs.sv ***
/*
  little register memory that holds the three initiator window map words.
  assumes single-port writes from the register port; read data is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module pwt_win_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    // read port
    input  wire logic [1:0]  rd_idx,
    output logic      [31:0] rd_data,
    // all words for decode
    output logic      [31:0] words [pwt_pkg::NUM_WIN]
);

    logic [31:0] mem_q [pwt_pkg::NUM_WIN];
    logic [31:0] mem_d [pwt_pkg::NUM_WIN];
    logic [31:0] rd_q;
    logic [31:0] rd_d;

    always_comb begin
        for (int i = 0; i < pwt_pkg::NUM_WIN; i++) begin
            mem_d[i] = mem_q[i];
            if (wr_en && wr_idx == 2'(i)) begin
                mem_d[i] = wr_data & pwt_pkg::MSK_INI_WIN_MAP;
            end
        end
        rd_d = (rd_idx < 2'h3) ? mem_q[rd_idx] : pwt_pkg::RST_ZERO;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < pwt_pkg::NUM_WIN; i++) begin
                mem_q[i] <= pwt_pkg::RST_ZERO;
            end
            rd_q <= pwt_pkg::RST_ZERO;
        end else begin
            mem_q <= mem_d;
            rd_q  <= rd_d;
        end
    end

    assign rd_data = rd_q;
    assign words   = mem_q;

endmodule
`default_nettype wire

// *** tb/pwt_pci_master.sv ***
/*
  pci master model on the far side: opens a frame, gives a first beat,
  then three more beats spaced by gap idle cycles, then releases the frame.
  assumes the bench pulses start once while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module pwt_pci_master (
    // clock
    input  wire logic       clk,
    // command from bench
    input  wire logic       start,
    input  wire logic [7:0] gap,
    // pci side
    output logic            frame_n,
    output logic            data_beat,
    output logic            first_beat,
    output logic            busy
);
    initial begin
        frame_n = 1'b1;
        data_beat = 1'b0;
        first_beat = 1'b0;
        busy = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // burst with slow or prompt data
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            frame_n <= 1'b0;
            repeat (4) @(posedge clk);
            data_beat <= 1'b1;
            first_beat <= 1'b1;
            for (int i = 0; i < 3; i++) begin
                @(posedge clk);
                data_beat <= 1'b0;
                first_beat <= 1'b0;
                repeat (gap) @(posedge clk);
                data_beat <= 1'b1;
            end
            @(posedge clk);
            data_beat <= 1'b0;
            frame_n <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/pci_window_translation_bench.sv ***
/*
  self-checking bench: registers, target remap, initiator windows, target flow.
  assumes pwt_top and the pci master model.
*/
`timescale 1ns/1ps
`default_nettype none
module pci_window_translation_bench;
    logic                  clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  reg_sel = 1'b0;
    logic                  reg_wr = 1'b0;
    logic [11:0]           reg_addr = 12'h000;
    logic [31:0]           reg_wdata = 32'h0, reg_rdata, rd;
    logic                  reg_ack, start = 1'b0, space = 1'b1, wfull = 1'b0, wopen = 1'b0;
    logic                  rdpf = 1'b0, wpost = 1'b0, iodone = 1'b0, rblk = 1'b0;
    logic                  frame_n, beat, first, busy, retry, deny, fetch, rretry, whold;
    logic [7:0]            gap = 8'h00;
    pwt_pkg::pwt_ini_req_t ini_req = '0;
    pwt_pkg::pwt_ini_ans_t ini_ans;
    pwt_pkg::pwt_tgt_req_t tgt_req = '0;
    pwt_pkg::pwt_tgt_ans_t tgt_ans;
    int                    err_count = 0, compares = 0, cycles = 0, retries = 0;
    logic [11:0] ofs [7] = '{pwt_pkg::OFS_TGT_WIN1_XLT, pwt_pkg::OFS_TGT_CONTROL,
        pwt_pkg::OFS_INI_WIN0_MAP, pwt_pkg::OFS_INI_WIN1_MAP, pwt_pkg::OFS_INI_WIN2_MAP,
        pwt_pkg::OFS_INI_WIN_CFG, pwt_pkg::OFS_CFG_ADDR};
    logic [31:0] msk [7] = '{pwt_pkg::MSK_TGT_WIN1_XLT, pwt_pkg::MSK_TGT_CONTROL,
        pwt_pkg::MSK_INI_WIN_MAP, pwt_pkg::MSK_INI_WIN_MAP, pwt_pkg::MSK_INI_WIN_MAP,
        pwt_pkg::MSK_INI_WIN_CFG, pwt_pkg::MSK_CFG_ADDR};
    logic [3:0]  ctl [6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'h7, 4'h9};

    pwt_top uut (.clk(clk), .reset_n(reset_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .ini_req(ini_req), .ini_ans(ini_ans), .tgt_req(tgt_req), .tgt_ans(tgt_ans),
        .pci_frame_pin_n(frame_n), .tgt_data_beat(beat), .tgt_first_beat(first),
        .rd_buf_space(space), .wr_buf_full(wfull), .int_write_open(wopen),
        .rd_prefetched(rdpf), .int_write_posted(wpost), .io_write_done(iodone),
        .int_read_blocked(rblk), .tgt_retry(retry), .tgt_deny_inbound(deny),
        .tgt_fetch_line(fetch), .int_read_retry(rretry), .int_write_hold(whold));
    pwt_pci_master peer (.clk(clk), .start(start), .gap(gap), .frame_n(frame_n),
        .data_beat(beat), .first_beat(first), .busy(busy));

    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // checking and access tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        reg_sel <= 1'b1;
        reg_wr <= wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_sel <= 1'b0;
        @(negedge clk);
        while (reg_ack !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk(reg_ack, 1);
        rd = reg_rdata;
    endtask
    task automatic ini(input logic w, input logic [31:0] a);
        @(posedge clk);
        ini_req <= '{1'b1, w, a};
        @(posedge clk);
        ini_req.valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic tgt(input logic m, input logic r, input logic [31:0] a);
        @(posedge clk);
        tgt_req <= '{1'b1, m, r, a};
        @(posedge clk);
        tgt_req.valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic burst(input logic [7:0] g);
        retries = 0;
        @(posedge clk);
        gap <= g;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (80) @(posedge clk);
    endtask
    function automatic logic [3:0] ecmd(input logic [3:0] c, input logic w, input logic m);
        if (c[3]) return m ? (w ? pwt_pkg::CMD_CFG_WR : pwt_pkg::CMD_CFG_RD)
                           : (w ? pwt_pkg::CMD_IO_WR : pwt_pkg::CMD_IO_RD);
        if (w) return pwt_pkg::CMD_MEM_WR;
        if (c[2:1] == pwt_pkg::RCS_LINE) return pwt_pkg::CMD_MEM_RD_L;
        if (c[2:1] == pwt_pkg::RCS_MULTIPLE) return pwt_pkg::CMD_MEM_RD_M;
        return pwt_pkg::CMD_MEM_RD;
    endfunction
    task automatic results();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (retry === 1'b1) retries++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rw(0, ofs[i], 0);
            chk(rd, 0);
            rw(1, ofs[i], 32'hFFFF_FFFF);
            rw(0, ofs[i], 0);
            chk(rd, msk[i]);
            rw(1, ofs[i], 0);
        end
        rw(1, 12'hB90, 32'hFFFF_FFFF);
        rw(0, 12'hB90, 0);
        chk(rd, 0);
        $display("test registers done");
        tgt(0, 1, 32'h1234_5678);
        chk(tgt_ans.abort, 1);
        rw(1, pwt_pkg::OFS_TGT_WIN1_XLT, 32'h8000_0001);
        tgt(0, 1, 32'h1234_5678);
        chk({tgt_ans.abort, tgt_ans.addr}, {1'b0, 32'h9234_5678});
        rw(1, pwt_pkg::OFS_TGT_WIN1_XLT, 32'h4000_0001);
        tgt(0, 1, 32'hF234_5678);
        chk(tgt_ans.addr, 32'h7234_5678);
        for (int i = 0; i < 4; i++) begin
            rw(1, pwt_pkg::OFS_TGT_CONTROL, {15'h0, i[1], 16'h0});
            tgt(i[0], 1, 32'h0);
            chk(tgt_ans.prefetch, i != 0);
        end
        tgt(0, 0, 32'h0);
        chk(tgt_ans.prefetch, 0);
        $display("test target remap done");
        rw(1, pwt_pkg::OFS_INI_WIN0_MAP, 32'h400F_A000);
        rw(1, pwt_pkg::OFS_INI_WIN1_MAP, 32'h403F_4000);
        rw(1, pwt_pkg::OFS_INI_WIN2_MAP, 32'hC000_C000);
        for (int i = 0; i < 6; i++) begin
            rw(1, pwt_pkg::OFS_INI_WIN_CFG, {4'h0, ctl[i], 4'h0, 4'h1, 4'h0, 4'h9, 8'h00});
            for (int w = 0; w < 2; w++) begin
                ini(w[0], 32'h4312_3456);
                if (ctl[i][0]) chk({ini_ans.hit, ini_ans.win, ini_ans.cmd, ini_ans.addr},
                    {3'b100, ecmd(ctl[i], w[0], 0), 32'hA312_3456});
                else chk({ini_ans.hit, ini_ans.win, ini_ans.cmd, ini_ans.addr},
                    {3'b101, ecmd(4'h1, w[0], 0), 32'h4312_3456});
            end
        end
        ini(0, 32'h5000_0000);
        chk(ini_ans.win, 1);
        ini(1, 32'hC0AB_CDEF);
        chk({ini_ans.hit, ini_ans.win, ini_ans.cmd, ini_ans.addr},
            {3'b110, pwt_pkg::CMD_IO_WR, 32'hC0AB_CDEF});
        rw(1, pwt_pkg::OFS_CFG_ADDR, 32'h8000_0000);
        ini(1, 32'hC0AB_CDEF);
        chk({ini_ans.cfg_cycle, ini_ans.cmd}, {1'b1, pwt_pkg::CMD_CFG_WR});
        rw(1, pwt_pkg::OFS_INI_WIN_CFG, 0);
        ini(0, 32'h4312_3456);
        chk(ini_ans.hit, 0);
        $display("test initiator windows done");
        burst(8'd12);
        chk(retries != 0, 1);
        burst(8'd2);
        chk(retries, 0);
        rw(1, pwt_pkg::OFS_TGT_CONTROL, 32'h0101_0000);
        burst(8'd12);
        chk(retries, 0);
        @(posedge clk);
        gap <= 8'd30;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        tgt(0, 1, 32'h0);
        @(negedge clk);
        chk(fetch, 1);
        @(posedge clk);
        space <= 1'b0;
        repeat (4) @(posedge clk);
        chk(fetch, 0);
        wait (busy === 1'b0);
        tgt_req <= '{1'b1, 1'b0, 1'b1, 32'h0};
        wopen <= 1'b1;
        wfull <= 1'b1;
        rblk <= 1'b1;
        repeat (4) @(posedge clk);
        chk({deny, rretry, whold}, 3'b111);
        wpost <= 1'b1;
        rblk <= 1'b0;
        repeat (4) @(posedge clk);
        chk({rretry, whold}, 2'b00);
        $display("test target flow done");
        results();
    end
endmodule
`default_nettype wire
